/* File: rtl/usbel_event_latch.sv */
// Event latch and line state debug registers
// Function
// - Unmasked source change sets its event flag
// - Reading latch register clears all flags
// - Entering low power clears all flags but a same-cycle event
// - Serial or car-kit entry clears all flags but a same-cycle event
// - Same-cycle event on a latch read goes to read data only
// - Flag bits: id, sess end, valid, vbus, disc
// - Session valid flag follows the A-valid comparator
// - Disconnect flag meaningful only in host role
// - Disconnect flag reset follows host connection
// - Debug register is read-only and live
// - Line field: bit0 positive, bit1 negative line
// - Value 0 means SE0 or squelch
// - Value 1 means K, J, or not-squelch
// - Value 2 means J, K, or invalid
// - Value 3 means SE1, invalid at high speed
`timescale 1ns/1ps
`default_nettype none
`include "usbel_map.svh"

module usbel_event_latch (
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  input  wire usbel_pkg::usbel_sig_t    sig_live,
  input  wire logic [`USBEL_EVT_W-1:0] rise_en,
  input  wire logic [`USBEL_EVT_W-1:0] fall_en,
  input  wire usbel_pkg::usbel_mode_t   mode,
  input  wire logic                     host_role,
  input  wire logic                     dp_se_rx,
  input  wire logic                     dm_se_rx,
  input  wire usbel_pkg::usbel_speed_t  speed,
  input  wire usbel_pkg::usbel_rd_t     rd,
  output logic      [`USBEL_DATA_W-1:0] rd_data_q,
  output logic                          rd_valid_q,
  output logic      [`USBEL_EVT_W-1:0] event_flags_q,
  output logic      [1:0]               line_level_q,
  output logic                          line_invalid_q
);

  usbel_pkg::usbel_state_t state_q;
  usbel_pkg::usbel_state_t state_d;
  usbel_pkg::usbel_mode_t  mode_q;

  logic [`USBEL_EVT_W-1:0] change;
  logic [`USBEL_EVT_W-1:0] set_now;
  logic [`USBEL_EVT_W-1:0] flags_d;
  logic [`USBEL_DATA_W-1:0] rd_data_d;
  logic [1:0]               line_now;
  logic                     line_invalid_d;

  wire active_w   = (state_q == usbel_pkg::USBEL_ST_ACTIVE);
  wire in_init_w  = (state_q == usbel_pkg::USBEL_ST_INIT);
  wire lp_entry   = mode.low_power & ~mode_q.low_power;
  wire ser_entry  = mode.serial_mode & ~mode_q.serial_mode;
  wire car_entry  = mode.carkit_mode & ~mode_q.carkit_mode;
  // Clock-suspend setting plays no part in these clears
  wire mode_clear = lp_entry | ser_entry | car_entry;
  wire hit_latch  = (rd.addr == `USBEL_OFS_EVT_LATCH);
  wire hit_debug  = (rd.addr == `USBEL_OFS_LINE_DEBUG);
  wire rd_latch   = rd.req & hit_latch;
  wire rd_debug   = rd.req & hit_debug;

  usbel_edge_detect u_edge (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .live     (sig_live),
    .rise_en  (rise_en),
    .fall_en  (fall_en),
    .change   (change)
  );

  // Session valid is the A-valid comparator, same input bit
  wire disc_ok_w = host_role;
  assign set_now = active_w ? (change & {{(`USBEL_EVT_W-1){1'b1}}, disc_ok_w})
                            : `USBEL_RST_EVT_LATCH;

  // Positive line in bit 0, negative line in bit 1, no latching
  assign line_now = {dm_se_rx, dp_se_rx};

  // Value 3 is invalid at HS and chirp, value 2 invalid at HS only
  always_comb
  begin
    line_invalid_d = 1'b0;
    case (line_now)
      `USBEL_LINE_SE0: line_invalid_d = 1'b0;
      `USBEL_LINE_ONE: line_invalid_d = 1'b0;
      `USBEL_LINE_TWO:
        line_invalid_d = (speed == usbel_pkg::USBEL_SPD_HS);
      `USBEL_LINE_SE1:
        line_invalid_d = (speed == usbel_pkg::USBEL_SPD_HS) |
                         (speed == usbel_pkg::USBEL_SPD_CHIRP);
      default: line_invalid_d = 1'b0;
    endcase
  end

  // Set wins over a same-cycle mode entry so no change is lost;
  // a latch read instead hands the event over in its read data.
  always_comb
  begin
    flags_d = event_flags_q;
    if (in_init_w)
      flags_d = {{(`USBEL_EVT_W-1){1'b0}}, sig_live.host_disconnect};
    else if (rd_latch)
      flags_d = `USBEL_RST_EVT_LATCH;
    else if (mode_clear)
      flags_d = set_now;
    else
      flags_d = event_flags_q | set_now;
  end

  // Reserved bits above the fields stay zero
  always_comb
  begin
    rd_data_d = `USBEL_RST_UNMAPPED;
    if (hit_latch)
      rd_data_d = {3'h0, event_flags_q | set_now};
    else if (hit_debug)
      rd_data_d = {6'h00, line_now};
    else
      rd_data_d = `USBEL_RST_UNMAPPED;
  end

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      usbel_pkg::USBEL_ST_INIT:   state_d = usbel_pkg::USBEL_ST_ACTIVE;
      usbel_pkg::USBEL_ST_ACTIVE: state_d = usbel_pkg::USBEL_ST_ACTIVE;
      default:                    state_d = usbel_pkg::USBEL_ST_INIT;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q       <= usbel_pkg::USBEL_ST_INIT;
      event_flags_q <= `USBEL_RST_EVT_LATCH;
      mode_q        <= '0;
    end
    else
    begin
      state_q       <= state_d;
      event_flags_q <= flags_d;
      mode_q        <= mode;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_data_q  <= `USBEL_RST_LINE_DEBUG;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= rd.req;
      if (rd.req)
        rd_data_q <= rd_data_d;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      line_level_q   <= `USBEL_LINE_SE0;
      line_invalid_q <= 1'b0;
    end
    else
    begin
      line_level_q   <= line_now;
      line_invalid_q <= line_invalid_d;
    end
  end

  // Checks on the flags, the read path and the line state outputs

  a_flag_sets: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (active_w && !rd_latch && (set_now != 5'h00))
    |=> ((event_flags_q & $past(set_now)) == $past(set_now)))
    else $error("event flag not set after unmasked change");

  a_read_clears: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (active_w && rd_latch) |=> (event_flags_q == 5'h00))
    else $error("latch read did not clear the flags");

  a_lowpwr_clears: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (active_w && $rose(mode.low_power))
    |=> ((event_flags_q & ~$past(set_now)) == 5'h00))
    else $error("low power entry did not clear the flags");

  a_mode_clears: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (active_w && ($rose(mode.serial_mode) || $rose(mode.carkit_mode)))
    |=> ((event_flags_q & ~$past(set_now)) == 5'h00))
    else $error("serial or car-kit entry did not clear the flags");

  a_same_cycle: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (active_w && rd_latch)
    |=> (rd_valid_q && (rd_data_q[4:0] == $past(event_flags_q | set_now))))
    else $error("same-cycle event missing from read data");

  a_id_position: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (active_w && !mode_clear && !rd_latch && $rose(sig_live.id_ground) && rise_en[4])
    ##1 (rd.req && hit_latch) |=> rd_data_q[`USBEL_BIT_ID_GROUND])
    else $error("id ground event not reported in bit 4");

  a_valid_tracks: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (active_w && !mode_clear && !rd_latch &&
     $fell(sig_live.session_valid) && fall_en[2])
    |=> event_flags_q[`USBEL_BIT_SESS_VALID])
    else $error("session valid change not latched");

  a_host_only: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (active_w && !host_role && !event_flags_q[0]) |=> !event_flags_q[0])
    else $error("disconnect flag set outside host role");

  a_reset_disc: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    in_init_w |=> (event_flags_q == {4'h0, $past(sig_live.host_disconnect)}))
    else $error("disconnect flag reset value wrong");

  a_debug_live: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    rd_debug |=> (rd_data_q == {6'h00, $past(dm_se_rx), $past(dp_se_rx)}))
    else $error("debug read does not show live line levels");

  a_line_invalid: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (dp_se_rx && dm_se_rx && (speed == usbel_pkg::USBEL_SPD_CHIRP))
    |=> (line_invalid_q && (line_level_q == 2'h3)))
    else $error("SE1 during chirp not flagged invalid");

  a_reserved_zero: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    rd_valid_q |-> (rd_data_q[7:5] == 3'h0))
    else $error("reserved read bits not zero");

  a_flags_sticky: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (active_w && !mode_clear && !rd_latch)
    |=> ((event_flags_q & $past(event_flags_q)) == $past(event_flags_q)))
    else $error("event flag lost without a clearing cause");

  a_only_enabled: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (active_w && !rd_latch)
    |=> ((event_flags_q & ~$past(event_flags_q) &
          ~(($past(sig_live) & ~$past(sig_live, 2) & $past(rise_en)) |
            (~$past(sig_live) & $past(sig_live, 2) & $past(fall_en)))) == 5'h00))
    else $error("event flag set without an enabled change");

  a_read_answer: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    rd.req |=> rd_valid_q)
    else $error("read request not answered next cycle");

  a_unmapped_zero: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (rd.req && !hit_latch && !hit_debug) |=> (rd_data_q == 8'h00))
    else $error("unmapped read did not return zero");

  a_line_mirror: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    1'b1 |=> (line_level_q == {$past(dm_se_rx), $past(dp_se_rx)}))
    else $error("line level does not mirror the receivers");

  a_se0_valid: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (!dp_se_rx && !dm_se_rx) |=> (!line_invalid_q && (line_level_q == 2'h0)))
    else $error("SE0 or squelch shown wrongly");

  a_one_valid: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (dp_se_rx && !dm_se_rx) |=> (!line_invalid_q && (line_level_q == 2'h1)))
    else $error("value one flagged invalid");

  a_two_invalid: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (!dp_se_rx && dm_se_rx)
    |=> ((line_level_q == 2'h2) &&
         (line_invalid_q == ($past(speed) == usbel_pkg::USBEL_SPD_HS))))
    else $error("value two validity wrong for the speed");

  a_se1_valid: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (dp_se_rx && dm_se_rx &&
     ((speed == usbel_pkg::USBEL_SPD_LS) || (speed == usbel_pkg::USBEL_SPD_FS)))
    |=> !line_invalid_q)
    else $error("SE1 at low or full speed flagged invalid");

  a_disc_host: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (active_w && host_role && !rd_latch && $rose(sig_live.host_disconnect) && rise_en[0])
    |=> event_flags_q[`USBEL_BIT_HOST_DISC])
    else $error("disconnect event lost in host role");

endmodule : usbel_event_latch
`default_nettype wire

/* File: rtl/usbel_map.svh */
// Register offsets, field positions and reset values of the event latch block
`ifndef USBEL_MAP_SVH
`define USBEL_MAP_SVH

`define USBEL_ADDR_W          6
`define USBEL_DATA_W          8
`define USBEL_EVT_W           5

`define USBEL_OFS_EVT_LATCH   6'h14
`define USBEL_OFS_LINE_DEBUG  6'h15

`define USBEL_BIT_ID_GROUND   4
`define USBEL_BIT_SESS_END    3
`define USBEL_BIT_SESS_VALID  2
`define USBEL_BIT_VBUS_VALID  1
`define USBEL_BIT_HOST_DISC   0

`define USBEL_BIT_LINE_DP     0
`define USBEL_BIT_LINE_DM     1

`define USBEL_RST_EVT_LATCH   5'h00
`define USBEL_RST_LINE_DEBUG  8'h00
`define USBEL_RST_UNMAPPED    8'h00

`define USBEL_LINE_SE0        2'h0
`define USBEL_LINE_ONE        2'h1
`define USBEL_LINE_TWO        2'h2
`define USBEL_LINE_SE1        2'h3

`endif

/* File: rtl/usbel_pkg.sv */
// Types shared by the event latch and line state block
`default_nettype none
package usbel_pkg;

  typedef struct packed {
    logic id_ground;
    logic session_end;
    logic session_valid;
    logic vbus_valid;
    logic host_disconnect;
  } usbel_sig_t;

  typedef struct packed {
    logic low_power;
    logic serial_mode;
    logic carkit_mode;
  } usbel_mode_t;

  typedef struct packed {
    logic       req;
    logic [5:0] addr;
  } usbel_rd_t;

  typedef enum logic [1:0] {
    USBEL_SPD_LS    = 2'h0,
    USBEL_SPD_FS    = 2'h1,
    USBEL_SPD_HS    = 2'h2,
    USBEL_SPD_CHIRP = 2'h3
  } usbel_speed_t;

  typedef enum logic [1:0] {
    USBEL_ST_INIT   = 2'b01,
    USBEL_ST_ACTIVE = 2'b10
  } usbel_state_t;

endpackage : usbel_pkg
`default_nettype wire

/* File: rtl/usbel_edge_detect.sv */
// Per-bit change detector gated by rise and fall enables
`timescale 1ns/1ps
`default_nettype none
`include "usbel_map.svh"

module usbel_edge_detect (
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  input  wire logic [`USBEL_EVT_W-1:0] live,
  input  wire logic [`USBEL_EVT_W-1:0] rise_en,
  input  wire logic [`USBEL_EVT_W-1:0] fall_en,
  output logic      [`USBEL_EVT_W-1:0] change
);

  logic [`USBEL_EVT_W-1:0] prev_q;
  logic [`USBEL_EVT_W-1:0] prev_d;

  assign prev_d = live;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      prev_q <= `USBEL_RST_EVT_LATCH;
    else
      prev_q <= prev_d;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `USBEL_EVT_W; gi = gi + 1)
    begin : g_bit
      wire rose_w = live[gi] & ~prev_q[gi];
      wire fell_w = ~live[gi] & prev_q[gi];
      // Unmasked only when the matching edge enable is set
      assign change[gi] = (rose_w & rise_en[gi]) | (fell_w & fall_en[gi]);
    end
  endgenerate

endmodule : usbel_edge_detect
`default_nettype wire

/* File: verif/usbel_link_model.sv */
// Link-side register reader for the event latch block
`timescale 1ns/1ps
`default_nettype none

module usbel_link_model (
  input  wire logic               core_clk,
  output var usbel_pkg::usbel_rd_t rd,
  input  wire logic [7:0]         rd_data_q,
  input  wire logic               rd_valid_q
);
  initial rd = '0;

  // Caller stands just after an edge; the answer is taken one edge later
  // Latch reads are issued only on command, so skipping them is legal
  task automatic read(input logic [5:0] addr, output logic [7:0] data, output logic ok);
    rd.req  = 1'b1;
    rd.addr = addr;
    @(posedge core_clk) #1;
    data    = rd_data_q;
    ok      = rd_valid_q;
    rd.req  = 1'b0;
    // Idle address flips so a stale value never looks like a request
    rd.addr = ~addr;
    // One idle edge so back-to-back calls never rewrite req in one step
    @(posedge core_clk) #1;
  endtask : read
endmodule : usbel_link_model

`default_nettype wire

/* File: verif/tb_usb_event_latch_and_line_state.sv */
// Self-checking bench for the event latch and line state block
`timescale 1ns/1ps
`default_nettype none
`include "usbel_map.svh"

module tb_usb_event_latch_and_line_state;
  logic                    core_clk  = 1'b0;
  logic                    reset_n   = 1'b0;
  usbel_pkg::usbel_sig_t   sig_live  = 5'h01;
  logic [4:0]              rise_en   = 5'h1f;
  logic [4:0]              fall_en   = 5'h00;
  usbel_pkg::usbel_mode_t  mode      = '0;
  logic                    host_role = 1'b1;
  logic                    dp_se_rx  = 1'b0;
  logic                    dm_se_rx  = 1'b0;
  usbel_pkg::usbel_speed_t speed     = usbel_pkg::USBEL_SPD_LS;
  usbel_pkg::usbel_rd_t    rd;
  logic [7:0]              rd_data_q;
  logic                    rd_valid_q;
  logic [4:0]              event_flags_q;
  logic [1:0]              line_level_q;
  logic                    line_invalid_q;
  logic [7:0]              rdat;
  logic                    rok;
  int                      err_count = 0;
  int                      samples_checked = 0;

  always #10 core_clk = ~core_clk;

  usbel_event_latch dut (
    .core_clk(core_clk), .reset_n(reset_n), .sig_live(sig_live), .rise_en(rise_en),
    .fall_en(fall_en), .mode(mode), .host_role(host_role), .dp_se_rx(dp_se_rx),
    .dm_se_rx(dm_se_rx), .speed(speed), .rd(rd), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .event_flags_q(event_flags_q), .line_level_q(line_level_q),
    .line_invalid_q(line_invalid_q)
  );

  usbel_link_model link (
    .core_clk(core_clk), .rd(rd), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q)
  );

  task automatic tick;
    @(posedge core_clk) #1;
  endtask : tick

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    link.read(a, rdat, rok);
    check({7'h0, rok}, 8'h01);
    check(rdat, exp);
  endtask : rd_chk

  task automatic t_reset_value;
    tick;
    tick;
    check({3'h0, event_flags_q}, 8'h01);
    rd_chk(`USBEL_OFS_EVT_LATCH, 8'h01);
    check({3'h0, event_flags_q}, 8'h00);
  endtask : t_reset_value

  task automatic t_mask_set;
    // Falling edges masked first, so this change must leave no trace
    sig_live.host_disconnect = 1'b0;
    tick;
    check({3'h0, event_flags_q}, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      sig_live = sig_live | 5'(1 << i);
      tick;
      check({3'h0, event_flags_q}, 8'(1 << i));
      rd_chk(`USBEL_OFS_EVT_LATCH, 8'(1 << i));
    end
    fall_en  = 5'h1f;
    sig_live = '0;
    tick;
    check({3'h0, event_flags_q}, 8'h1f);
    rd_chk(`USBEL_OFS_EVT_LATCH, 8'h1f);
    rd_chk(`USBEL_OFS_EVT_LATCH, 8'h00);
  endtask : t_mask_set

  task automatic t_clear_modes;
    for (int m = 0; m < 3; m++)
    begin
      sig_live.vbus_valid = ~sig_live.vbus_valid;
      tick;
      check({3'h0, event_flags_q}, 8'h02);
      mode = 3'(1 << m);
      tick;
      check({3'h0, event_flags_q}, 8'h00);
      mode = '0;
      tick;
    end
    // Event in the entry cycle survives the clear
    sig_live.id_ground = ~sig_live.id_ground;
    mode.low_power = 1'b1;
    tick;
    check({3'h0, event_flags_q}, 8'h10);
    rd_chk(`USBEL_OFS_EVT_LATCH, 8'h10);
    mode = '0;
  endtask : t_clear_modes

  task automatic t_same_cycle;
    sig_live.session_end = 1'b1;
    rd_chk(`USBEL_OFS_EVT_LATCH, 8'h08);
    check({3'h0, event_flags_q}, 8'h00);
  endtask : t_same_cycle

  task automatic t_host_only;
    host_role = 1'b0;
    sig_live.host_disconnect = 1'b1;
    tick;
    check({3'h0, event_flags_q}, 8'h00);
    rd_chk(`USBEL_OFS_EVT_LATCH, 8'h00);
    rd_chk(6'h16, 8'h00);
    host_role = 1'b1;
  endtask : t_host_only

  task automatic t_debug;
    for (int s = 0; s < 4; s++)
    begin
      for (int v = 0; v < 4; v++)
      begin
        speed = usbel_pkg::usbel_speed_t'(2'(s));
        {dm_se_rx, dp_se_rx} = 2'(v);
        tick;
        check({6'h0, line_level_q}, 8'(v));
        check({7'h0, line_invalid_q}, {7'h0, (v == 3 && s > 1) || (v == 2 && s == 2)});
        rd_chk(`USBEL_OFS_LINE_DEBUG, 8'(v));
      end
    end
  endtask : t_debug

  task automatic results;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  initial
  begin
    repeat (6) @(posedge core_clk);
    #1 reset_n = 1'b1;
    t_reset_value();
    t_mask_set();
    t_clear_modes();
    t_same_cycle();
    t_host_only();
    t_debug();
    results();
  end

  // Run needs about a hundred cycles; allow some twenty times that
  initial
  begin
    #40000;
    err_count++;
    results();
  end
endmodule : tb_usb_event_latch_and_line_state

`default_nettype wire
